// [rtl/ddr3_timing_defines.svh]
/*
  Timing constants for the DDR3 command timing guard.
  Assumes the memory clock runs at 125 MHz (8 ns period); limits are taken
  from the speed-bin table of the attached memory, not the run frequency.
*/
// What this block does
// R1 - After the memory reset is released, clock enable stays low for at least the init interval.
// R2 - Two mode register set commands are spaced by at least the mode-register cycle time.
// R3 - A precharge waits at least the activate-to-precharge time after the activate.
// R4 - A read or write waits at least the activate-to-column delay after the activate.
// R5 - An activate waits at least the precharge period after a precharge.
// R6 - A precharge waits the write recovery interval in cycles after a write.
// R7 - Every timing limit is a configuration value taken from the speed-bin table.
// R8 - Times are rounded up to clock cycles and each spacing limit (R2-R6) has its own down-counter; the init interval counts up.
`ifndef DDR3_TIMING_DEFINES_SVH
`define DDR3_TIMING_DEFINES_SVH

`define CLK_PERIOD_PS 8000
`define TINIT_US 500
`define TMRD_CK 4
`define TRAS_NS 35
`define TRCD_NS 14
`define TRP_NS 14
`define TWR_NS 15
`define NS_TO_CYC(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define US_TO_CYC(us) (((us) * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CNT_W 16

`endif

// [rtl/ddr3_timing_pkg.sv]
/*
  Types for the DDR3 command timing guard.
  Assumes nothing beyond the defines header.
*/
package ddr3_timing_pkg;
  // memory command as presented by the controller
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MRS = 3'h1,
    CMD_ACT = 3'h2,
    CMD_RD = 3'h3,
    CMD_WR = 3'h4,
    CMD_PRE = 3'h5
  } cmd_type;

  // power-up sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_INIT = 3'h2,
    ST_RUN = 3'h4
  } init_state_type;
endpackage

// [rtl/gap_counter.sv]
/*
  One down-counter that holds off a command class after an event.
  Assumes the load value is at least one and the clock is the memory clock.
*/
`timescale 1ns/100ps
`include "ddr3_timing_defines.svh"
module gap_counter
  import ddr3_timing_pkg::*;
#(
  parameter logic [`CNT_W-1:0] LOAD = 16'h0001
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o
);
  logic [`CNT_W-1:0] count_q;

  // reload on event, else count to zero; busy while nonzero
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      count_q <= '0;
    else if (start_i)
      count_q <= LOAD - 16'h0001; // the issue cycle counts as one R8
    else if (count_q != '0)
      count_q <= count_q - 16'h0001;
  end

  assign busy_o = (count_q != '0);
endmodule // gap_counter

// [rtl/ddr3_timing_guard.sv]
/*
  DDR3 command timing guard: sequences reset and clock enable at power-up,
  then passes controller commands to the memory only when every spacing
  limit is met, stalling the controller otherwise.
  Assumes a single open-row tracking for one bank; the controller holds its
  command stable while ready is low.
*/
`timescale 1ns/100ps
`include "ddr3_timing_defines.svh"
module ddr3_timing_guard
  import ddr3_timing_pkg::*;
#(
  parameter int unsigned INIT_CYC = `US_TO_CYC(`TINIT_US) // R7
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire cmd_type cmd_i,
  output logic cmd_ready_o,
  output logic mem_reset_n_o,
  output logic mem_cke_o,
  output logic mem_cmd_valid_o,
  output cmd_type mem_cmd_o,
  output logic init_done_o
);
  // cycle counts, rounded up from the speed-bin times
  localparam logic [`CNT_W-1:0] MRD_CYC = `CNT_W'(`TMRD_CK); // R7
  localparam logic [`CNT_W-1:0] RAS_CYC = `CNT_W'(`NS_TO_CYC(`TRAS_NS)); // R8
  localparam logic [`CNT_W-1:0] RCD_CYC = `CNT_W'(`NS_TO_CYC(`TRCD_NS)); // R8
  localparam logic [`CNT_W-1:0] RP_CYC = `CNT_W'(`NS_TO_CYC(`TRP_NS)); // R8
  localparam logic [`CNT_W-1:0] WR_CYC = `CNT_W'(`NS_TO_CYC(`TWR_NS)); // R8
  localparam logic [31:0] INIT_LAST = 32'(INIT_CYC - 1);

  init_state_type state_q;
  logic [31:0] init_cnt_q;
  logic mrd_busy, ras_busy, rcd_busy, rp_busy, wr_busy;
  logic allowed;
  logic issue;

  // power-up: hold reset for one cycle, then wait the init time before cke
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_RESET;
      init_cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_RESET:
        begin
          state_q <= ST_INIT;
          init_cnt_q <= '0;
        end
        ST_INIT:
        begin
          if (init_cnt_q == INIT_LAST)
            state_q <= ST_RUN; // R1
          else
            init_cnt_q <= init_cnt_q + 32'h00000001;
        end
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_RESET;
      endcase
    end
  end

  // pins come from flops so the memory sees clean levels
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      mem_reset_n_o <= 1'b0;
      mem_cke_o <= 1'b0;
    end
    else
    begin
      mem_reset_n_o <= (state_q != ST_RESET);
      mem_cke_o <= (state_q == ST_RUN); // R1
    end
  end

  assign init_done_o = mem_cke_o;

  // separate counter per limit, so overlapping windows never mask each other
  gap_counter #(.LOAD(MRD_CYC)) u_mrd
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(issue && cmd_i == CMD_MRS),
    .busy_o(mrd_busy)
  );
  gap_counter #(.LOAD(RAS_CYC)) u_ras
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(issue && cmd_i == CMD_ACT),
    .busy_o(ras_busy)
  );
  gap_counter #(.LOAD(RCD_CYC)) u_rcd
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(issue && cmd_i == CMD_ACT),
    .busy_o(rcd_busy)
  );
  gap_counter #(.LOAD(RP_CYC)) u_rp
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(issue && cmd_i == CMD_PRE),
    .busy_o(rp_busy)
  );
  gap_counter #(.LOAD(WR_CYC)) u_wr
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(issue && cmd_i == CMD_WR),
    .busy_o(wr_busy)
  );

  // gate each command class on the windows that apply to it
  always_comb
  begin
    case (cmd_i)
      CMD_MRS: allowed = !mrd_busy; // R2
      CMD_ACT: allowed = !rp_busy; // R5
      CMD_RD: allowed = !rcd_busy; // R4
      CMD_WR: allowed = !rcd_busy; // R4
      CMD_PRE: allowed = !ras_busy && !wr_busy; // R3 R6
      CMD_NOP: allowed = 1'b1;
      default: allowed = 1'b0;
    endcase
  end

  // nothing passes before cke is up; stall is a plain ready
  assign cmd_ready_o = mem_cke_o && allowed;
  assign issue = cmd_valid_i && cmd_ready_o;

  // registered command to the memory, a one-cycle pulse per issue
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      mem_cmd_valid_o <= 1'b0;
      mem_cmd_o <= CMD_NOP;
    end
    else
    begin
      mem_cmd_valid_o <= issue;
      mem_cmd_o <= issue ? cmd_i : CMD_NOP;
    end
  end
endmodule // ddr3_timing_guard

// [testbench/ddr3_mem_model.sv]
/* memory-side model: counts spacing violations seen on the command pins.
   Assumes commands arrive as one-cycle valid pulses. */
`timescale 1ns/100ps
module ddr3_mem_model
  import ddr3_timing_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic mem_cke_i,
  input wire logic mem_cmd_valid_i,
  input wire cmd_type mem_cmd_i,
  output int viol_o = 0
);
  int s_mrs = 9;
  int s_act = 9;
  int s_pre = 9;
  int s_wr = 9;
  wire logic v = mem_cmd_valid_i;
  wire cmd_type c = mem_cmd_i;
  // cycles since each MRS, ACT, PRE and WR; a device would misbehave on a short gap
  always @(posedge clk_sys_i)
  begin
    if (v && (!mem_cke_i || (c == CMD_MRS && s_mrs < 4)
        || (c == CMD_PRE && (s_act < 5 || s_wr < 2))
        || ((c == CMD_RD || c == CMD_WR) && s_act < 2)
        || (c == CMD_ACT && s_pre < 2)))
      viol_o <= viol_o + 1;
    s_mrs <= (v && c == CMD_MRS) ? 1 : s_mrs + 1;
    s_act <= (v && c == CMD_ACT) ? 1 : s_act + 1;
    s_pre <= (v && c == CMD_PRE) ? 1 : s_pre + 1;
    s_wr <= (v && c == CMD_WR) ? 1 : s_wr + 1;
  end
endmodule // ddr3_mem_model

// [testbench/ddr3_timing_guard_assertions.sv]
/* checker on the guard's ports.
   Assumes one clock and a synchronous high reset. */
`timescale 1ns/100ps
module ddr3_timing_guard_chk
  import ddr3_timing_pkg::*;
#(
  parameter int unsigned INIT_CYC = 10
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire cmd_type cmd_i,
  input wire logic cmd_ready_o,
  input wire logic mem_reset_n_o,
  input wire logic mem_cke_o,
  input wire logic mem_cmd_valid_o,
  input wire cmd_type mem_cmd_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // issued-command decodes
  wire logic i_mrs = mem_cmd_valid_o && mem_cmd_o == CMD_MRS;
  wire logic i_act = mem_cmd_valid_o && mem_cmd_o == CMD_ACT;
  wire logic i_pre = mem_cmd_valid_o && mem_cmd_o == CMD_PRE;
  wire logic i_wr = mem_cmd_valid_o && mem_cmd_o == CMD_WR;
  wire logic i_rd = mem_cmd_valid_o && mem_cmd_o == CMD_RD;
  sequence s_mrd_gap; !i_mrs [*3]; endsequence
  sequence s_ras_gap; !i_pre [*4]; endsequence
  property p_init;
    $rose(mem_cke_o) |-> $past(mem_reset_n_o, INIT_CYC) &&
      !$past(mem_reset_n_o, INIT_CYC + 1);
  endproperty
  property p_gate; !mem_cke_o |-> !cmd_ready_o; endproperty
  property p_take;
    cmd_valid_i && cmd_ready_o |=> mem_cmd_valid_o &&
      mem_cmd_o == $past(cmd_i);
  endproperty
  property p_mrd; i_mrs |=> s_mrd_gap; endproperty
  property p_ras; i_act |=> s_ras_gap; endproperty
  property p_rcd; i_act |=> !(i_rd || i_wr); endproperty
  property p_rp; i_pre |=> !i_act; endproperty
  property p_wr; i_wr |=> !i_pre; endproperty
  a_init: assert property (p_init) else $error("cke rose early");
  a_gate: assert property (p_gate) else $error("ready before cke");
  a_take: assert property (p_take) else $error("command lost");
  a_mrd: assert property (p_mrd) else $error("mrs gap short");
  a_ras: assert property (p_ras) else $error("act-pre short");
  a_rcd: assert property (p_rcd) else $error("act-col short");
  a_rp: assert property (p_rp) else $error("pre-act short");
  a_wr: assert property (p_wr) else $error("wr-pre short");
endmodule // ddr3_timing_guard_chk
bind ddr3_timing_guard ddr3_timing_guard_chk #(.INIT_CYC(INIT_CYC)) chk_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .mem_reset_n_o(mem_reset_n_o),
  .mem_cke_o(mem_cke_o), .mem_cmd_valid_o(mem_cmd_valid_o),
  .mem_cmd_o(mem_cmd_o));

// [testbench/ddr3_timing_guard_test.sv]
/* self-checking bench for the guard.
   Assumes the memory model flags gaps it sees on the pins. */
`timescale 1ns/100ps
module ddr3_timing_guard_test;
  import ddr3_timing_pkg::*;
  localparam int unsigned INIT = 10;
  logic clk = 0;
  logic rst = 1;
  logic v = 0;
  cmd_type c = CMD_NOP;
  logic rdy, rn, cke, mv, done;
  cmd_type mc;
  int err_count = 0;
  int checked = 0;
  int viol;
  int cyc = 0;
  ddr3_timing_guard #(.INIT_CYC(INIT)) ddr3_timing_guard_inst (
    .clk_sys_i(clk), .rst_i(rst), .cmd_valid_i(v), .cmd_i(c),
    .cmd_ready_o(rdy), .mem_reset_n_o(rn), .mem_cke_o(cke),
    .mem_cmd_valid_o(mv), .mem_cmd_o(mc), .init_done_o(done));
  ddr3_mem_model ddr3_mem_model_inst (.clk_sys_i(clk), .mem_cke_i(cke),
    .mem_cmd_valid_i(mv), .mem_cmd_i(mc), .viol_o(viol));
  // 8 ns memory clock
  initial forever #4 clk = ~clk;
  task give_verdict;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (e !== s)
    begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  // request held until taken; waits counted in whole cycles
  task issue(input cmd_type k, input int w);
    int n;
    n = 0;
    v = 1;
    c = k;
    #1;
    while (rdy !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    check("wait", w, n);
    check("mem_cmd", {1'b1, k}, {mv, mc});
  endtask
  task idle(input int n);
    v = 0;
    repeat (n) @(negedge clk);
  endtask
  task t_init;
    rst = 0;
    issue(CMD_MRS, INIT + 2);
    check("rn", 16'h0003, {rn, done});
  endtask
  task t_mrs;
    issue(CMD_MRS, 3);
    issue(CMD_MRS, 3);
  endtask
  task t_row;
    issue(CMD_ACT, 0);
    issue(CMD_RD, 1);
    issue(CMD_WR, 0);
    issue(CMD_PRE, 1);
    issue(CMD_ACT, 1);
    idle(8);
  endtask
  task t_wr;
    issue(CMD_WR, 0);
    issue(CMD_PRE, 1);
    idle(2);
  endtask
  // tras alone: no write overlaps, a nop slips through the window
  task t_ras;
    issue(CMD_ACT, 0);
    issue(CMD_NOP, 0);
    issue(CMD_PRE, 3);
    issue(CMD_ACT, 1);
    issue(CMD_WR, 1);
    idle(8);
  endtask
  // mid-run reset drops the pins and restarts the init wait
  task t_rerst;
    rst = 1;
    repeat (2) @(negedge clk);
    check("rst", 16'h0000, {rn, cke});
    rst = 0;
    issue(CMD_MRS, INIT + 2);
    check("rn", 16'h0003, {rn, done});
  endtask
  // hang guard well past the roughly 80 cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_count++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (5) @(negedge clk);
    t_init;
    t_mrs;
    t_row;
    t_wr;
    t_ras;
    t_rerst;
    check("viol", 16'h0000, viol[15:0]);
    give_verdict;
  end
endmodule // ddr3_timing_guard_test
